// ---- hdl/spb_pkg.sv ----
/*
  Shared constants for the serial port register block: register addresses,
  field positions, reset values, mode codes, baud divisors and frame states.
  Assumes an 8-bit special-function-register port on a single system clock.
*/
package spb_pkg;
  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_POWER_AND_SERIAL_CONTROL  = 8'h87;
  localparam logic [7:0] ADDR_SERIAL_CONTROL_REG  = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_DATA_BUFFER  = 8'h99;
  localparam logic [7:0] ADDR_NODE_SLAVE_ADDRESS = 8'h9a;
  localparam logic [7:0] ADDR_SMASK = 8'h9b;
  localparam logic [7:0] ADDR_RXTHR = 8'h9f;

  // ==========================================================================
  // Field positions
  localparam int POWER_AND_SERIAL_CONTROL_DBL  = 7;
  localparam int POWER_AND_SERIAL_CONTROL_VIEW = 6;
  localparam int POWER_AND_SERIAL_CONTROL_GFH  = 3;
  localparam int POWER_AND_SERIAL_CONTROL_GFL  = 2;
  localparam int POWER_AND_SERIAL_CONTROL_PD   = 1;
  localparam int POWER_AND_SERIAL_CONTROL_IDL  = 0;
  localparam int SERIAL_CONTROL_REG_TOPH = 7;
  localparam int SERIAL_CONTROL_REG_TOPL = 5;
  localparam int SERIAL_CONTROL_REG_REN  = 4;
  localparam int SERIAL_CONTROL_REG_TB8  = 3;
  localparam int SERIAL_CONTROL_REG_TI   = 1;
  localparam int SERIAL_CONTROL_REG_RI   = 0;
  localparam int THR_HI    = 1;
  localparam int THR_LO    = 0;

  // ==========================================================================
  // Reset values and codes
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [1:0] THR_RESET  = 2'h0;
  localparam logic [1:0] THR_NORMAL = 2'h3;
  localparam logic [1:0] MODE_SYNC  = 2'h0;
  localparam logic [1:0] MODE_ASY8  = 2'h1;
  localparam logic [1:0] MODE_FIX9  = 2'h2;
  localparam logic [2:0] LAST_BIT   = 3'h7;

  // ==========================================================================
  // Baud divisors, in units per bit
  localparam int         DIV_W        = 7;
  localparam logic [6:0] DIV_SYNC_SLO = 7'h0c;
  localparam logic [6:0] DIV_SYNC_FST = 7'h04;
  localparam logic [6:0] DIV_FIX      = 7'h40;
  localparam logic [6:0] DIV_FIX_DBL  = 7'h20;
  localparam logic [6:0] DIV_VAR      = 7'h10;
  localparam logic [6:0] DIV_VAR_DBL  = 7'h08;

  // ==========================================================================
  // Transmit buffer shape and frame states
  localparam int FIFO_W     = 9;
  localparam int FIFO_DEPTH = 4;

  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_NINTH, ST_STOP} spb_frame_st_t;
endpackage

// ---- hdl/spb_stream_if.sv ----
/*
  Valid/ready word carrier between the register block and its transmit buffer.
  Assumes both ends run on the same clock.
*/
interface spb_stream_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- hdl/spb_fifo.sv ----
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
module spb_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 4
) (
  input wire logic   sys_clk,
  input wire logic   rst_n,
  spb_stream_if.snk  in_s,
  spb_stream_if.src  out_s
);
  import spb_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } spb_fifo_st_t;

  spb_fifo_st_t st_q;
  spb_fifo_st_t st_d;
  logic         push;
  logic         pop;

  // Honest full and empty
  assign in_s.ready  = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_s.valid = (st_q.cnt != '0);
  assign out_s.data  = st_q.mem[st_q.rp];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  // Next state of pointers and storage
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = in_s.data;
      st_d.wp = (st_q.wp == AW'(DEPTH-1)) ? '0 : st_q.wp + AW'(1);
    end
    if (pop) begin
      st_d.rp = (st_q.rp == AW'(DEPTH-1)) ? '0 : st_q.rp + AW'(1);
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  fifo_full_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !in_s.ready |-> st_q.cnt == (AW+1)'(DEPTH) && out_s.valid)
    else $error("fifo ready low while not full");
endmodule // spb_fifo

// ---- hdl/spb_baud.sv ----
/*
  Restartable bit timer: counts units per bit, flags mid-bit and bit end.
  Assumes unit_i is a one-cycle pulse on the system clock.
*/
module spb_baud #(
  parameter int CW = 7
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic          unit_i,
  input  wire logic          restart_i,
  input  wire logic [CW-1:0] period_i,
  output logic               tick_o,
  output logic               mid_o
);
  import spb_pkg::*;

  typedef struct packed {
    logic [CW-1:0] cnt;
  } spb_baud_st_t;

  spb_baud_st_t st_q;
  spb_baud_st_t st_d;

  // Bit end and sampling point pulses
  assign tick_o = unit_i && !restart_i && (st_q.cnt == period_i - CW'(1));
  assign mid_o  = unit_i && !restart_i && (st_q.cnt == (period_i >> 1));

  // Unit counter, cleared on restart or at bit end
  always_comb begin
    st_d = st_q;
    if (restart_i || tick_o) begin
      st_d.cnt = '0;
    end else if (unit_i) begin
      st_d.cnt = st_q.cnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  count_in_range_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($stable(period_i) && $past(st_q.cnt) < period_i && !restart_i) |-> st_q.cnt < period_i)
    else $error("bit timer ran past its period");
endmodule // spb_baud

// ---- hdl/spb_serial_ctrl.sv ----
/*
  Register side of an enhanced serial port: data buffer, power control,
  serial control with status view, slave address match and receive threshold.
  Assumes an 8-bit register port on sys_clk and a timer overflow pulse.
*/
// Behaviour
// - A write to the data buffer, unless it is full, queues the byte and starts a new transmit frame.
// - A read of the data buffer returns the receive latch, not the transmit byte.
// - The doubler bit halves the bit time in modes 1 and 3 on the timer clock.
// - The doubler bit halves the fixed bit time in mode 2.
// - The view-select bit swaps control bits 7 to 5 between mode bits and error flags.
// - The slave address register holds this node's own 8-bit address.
// - Each mask bit at 1 compares its slave address bit, at 0 makes it don't-care.
// - The 2-bit threshold field chooses the receive pin input low level.
// - The threshold choice applies only while the port is on, else normal input.
// - Power control bits 3 to 2 are plain software storage.
// - Power control bit 1 requests power-down.
// - Power control bit 0 requests idle.
// - With the view bit at 0 the mode field picks one of four serial modes.
// - In modes 2 and 3 with multiprocessor enable, only ninth-bit-set bytes raise receive.
// - Hardware sets the frame error flag and only software clears it.
module spb_serial_ctrl (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       timer4_ovf,
  input  wire logic       rxd_pin,
  output logic            txd_pin,
  output logic            shift_clk,
  output logic      [1:0] rx_threshold_sel,
  output logic            powerdown_request,
  output logic            idle_request,
  output logic            tx_buf_ready
);
  import spb_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic          baud_doubler;
    logic          status_view_select;
    logic [1:0]    general_flags;
    logic          powerdown_req;
    logic          idle_req;
    logic [1:0]    serial_mode_field;
    logic          multiproc_enable;
    logic          rx_enable;
    logic          tx_bit9;
    logic          rx_bit9;
    logic          transmit_flag;
    logic          receive_flag;
    logic          frame_error_flag;
    logic          receive_overrun_flag;
    logic          transmit_collision_flag;
    logic [7:0]    node_slave_address;
    logic [7:0]    node_address_mask;
    logic [1:0]    threshold_field;
    logic [1:0]    threshold_pin;
    logic [7:0]    rx_latch;
    logic [7:0]    rdata;
    spb_frame_st_t tx_st;
    logic [8:0]    tx_sh;
    logic [2:0]    tx_cnt;
    logic          txd;
    logic          sclk;
    spb_frame_st_t rx_st;
    logic [8:0]    rx_sh;
    logic [2:0]    rx_cnt;
    logic          rxd_meta;
    logic          rxd_sync;
  } spb_ctrl_st_t;

  spb_ctrl_st_t st_q;
  spb_ctrl_st_t st_d;

  logic             wr_serial_data_buffer;
  logic             wr_serial_control_reg;
  logic             nine_bit;
  logic             unit;
  logic [DIV_W-1:0] period;
  logic             tx_load;
  logic             tx_tick;
  logic             tx_mid;
  logic             rx_go;
  logic             rx_tick;
  logic             rx_mid;
  logic [7:0]       rx_byte;
  logic             rx_b9;
  logic             addr_match;
  logic             accept;
  logic [7:0]       rd_mux;

  spb_stream_if #(.W(FIFO_W)) push_s ();
  spb_stream_if #(.W(FIFO_W)) pop_s ();

  assign wr_serial_data_buffer  = sfr_wr && (sfr_addr == ADDR_SERIAL_DATA_BUFFER);
  assign wr_serial_control_reg  = sfr_wr && (sfr_addr == ADDR_SERIAL_CONTROL_REG);
  assign nine_bit = st_q.serial_mode_field[1];

  // ==========================================================================
  // Transmit buffer
  // buffer write queues
  assign push_s.valid = wr_serial_data_buffer;
  assign push_s.data  = {st_q.tx_bit9, sfr_wdata};
  assign tx_buf_ready = push_s.ready;
  assign pop_s.ready  = (st_q.tx_st == ST_IDLE);
  assign tx_load      = pop_s.valid && pop_s.ready;

  spb_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_txbuf (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .in_s    (push_s),
    .out_s   (pop_s)
  );

  // ==========================================================================
  // Bit timing
  // mode picks clock source
  always_comb begin
    unit   = 1'b1;
    period = DIV_FIX;
    unique case (st_q.serial_mode_field)
      MODE_SYNC: period = st_q.multiproc_enable ? DIV_SYNC_FST : DIV_SYNC_SLO;
      MODE_FIX9: period = st_q.baud_doubler ? DIV_FIX_DBL : DIV_FIX;
      default: begin
        unit   = timer4_ovf;
        period = st_q.baud_doubler ? DIV_VAR_DBL : DIV_VAR;
      end
    endcase
  end

  spb_baud #(.CW(DIV_W)) u_txbaud (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .unit_i    (unit),
    .restart_i (tx_load),
    .period_i  (period),
    .tick_o    (tx_tick),
    .mid_o     (tx_mid)
  );

  assign rx_go = (st_q.rx_st == ST_IDLE) && st_q.rx_enable && (st_q.serial_mode_field != MODE_SYNC)
                 && !st_q.rxd_sync;

  spb_baud #(.CW(DIV_W)) u_rxbaud (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .unit_i    (unit),
    .restart_i (rx_go),
    .period_i  (period),
    .tick_o    (rx_tick),
    .mid_o     (rx_mid)
  );

  // ==========================================================================
  // Receive decode
  assign rx_byte    = nine_bit ? st_q.rx_sh[7:0] : st_q.rx_sh[8:1];
  assign rx_b9      = nine_bit ? st_q.rx_sh[8] : st_q.rxd_sync;
  assign addr_match = ((rx_byte ^ st_q.node_slave_address) & st_q.node_address_mask) == RST_BYTE;
  assign accept     = !st_q.multiproc_enable || (nine_bit ? (rx_b9 && addr_match) : st_q.rxd_sync);

  // Register read view
  always_comb begin
    rd_mux = RST_BYTE;
    unique case (sfr_addr)
      ADDR_SERIAL_DATA_BUFFER:  rd_mux = st_q.rx_latch;
      ADDR_POWER_AND_SERIAL_CONTROL:  rd_mux = {st_q.baud_doubler, st_q.status_view_select, 2'h0, st_q.general_flags,
                            st_q.powerdown_req, st_q.idle_req};
      ADDR_SERIAL_CONTROL_REG: begin
        rd_mux = {st_q.serial_mode_field, st_q.multiproc_enable, st_q.rx_enable, st_q.tx_bit9,
                  st_q.rx_bit9, st_q.transmit_flag, st_q.receive_flag};
        if (st_q.status_view_select) begin
          rd_mux[SERIAL_CONTROL_REG_TOPH:SERIAL_CONTROL_REG_TOPL] = {st_q.frame_error_flag, st_q.receive_overrun_flag,
                                         st_q.transmit_collision_flag};
        end
      end
      ADDR_NODE_SLAVE_ADDRESS: rd_mux = st_q.node_slave_address;
      ADDR_SMASK: rd_mux = st_q.node_address_mask;
      ADDR_RXTHR: rd_mux = {6'h00, st_q.threshold_field};
      default:    rd_mux = RST_BYTE;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_d = st_q;
    // Pin synchroniser
    st_d.rxd_meta = rxd_pin;
    st_d.rxd_sync = st_q.rxd_meta;
    if (sfr_rd) begin
      st_d.rdata = rd_mux;
    end
    if (sfr_wr && sfr_addr == ADDR_POWER_AND_SERIAL_CONTROL) begin
      st_d.baud_doubler       = sfr_wdata[POWER_AND_SERIAL_CONTROL_DBL];
      st_d.status_view_select = sfr_wdata[POWER_AND_SERIAL_CONTROL_VIEW];
      st_d.general_flags      = sfr_wdata[POWER_AND_SERIAL_CONTROL_GFH:POWER_AND_SERIAL_CONTROL_GFL];
      st_d.powerdown_req      = sfr_wdata[POWER_AND_SERIAL_CONTROL_PD];
      st_d.idle_req           = sfr_wdata[POWER_AND_SERIAL_CONTROL_IDL];
    end
    if (wr_serial_control_reg) begin
      if (st_q.status_view_select) begin
        // Error flags clear on written zero
        st_d.frame_error_flag        = st_q.frame_error_flag & sfr_wdata[SERIAL_CONTROL_REG_TOPH];
        st_d.receive_overrun_flag    = st_q.receive_overrun_flag & sfr_wdata[SERIAL_CONTROL_REG_TOPH-1];
        st_d.transmit_collision_flag = st_q.transmit_collision_flag & sfr_wdata[SERIAL_CONTROL_REG_TOPL];
      end else begin
        st_d.serial_mode_field = sfr_wdata[SERIAL_CONTROL_REG_TOPH:SERIAL_CONTROL_REG_TOPH-1];
        st_d.multiproc_enable  = sfr_wdata[SERIAL_CONTROL_REG_TOPL];
      end
      st_d.rx_enable     = sfr_wdata[SERIAL_CONTROL_REG_REN];
      st_d.tx_bit9       = sfr_wdata[SERIAL_CONTROL_REG_TB8];
      st_d.transmit_flag = sfr_wdata[SERIAL_CONTROL_REG_TI];
      st_d.receive_flag  = sfr_wdata[SERIAL_CONTROL_REG_RI];
    end
    if (sfr_wr && sfr_addr == ADDR_NODE_SLAVE_ADDRESS) begin
      st_d.node_slave_address = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == ADDR_SMASK) begin
      st_d.node_address_mask = sfr_wdata;
    end
    if (sfr_wr && sfr_addr == ADDR_RXTHR) begin
      st_d.threshold_field = sfr_wdata[THR_HI:THR_LO];
    end
    st_d.threshold_pin = st_q.rx_enable ? st_q.threshold_field : THR_NORMAL;
    // Write to a full buffer is a collision
    if (wr_serial_data_buffer && !push_s.ready) begin
      st_d.transmit_collision_flag = 1'b1;
    end

    // Transmit frame
    if (tx_load) begin
      st_d.tx_sh  = pop_s.data;
      st_d.tx_cnt = '0;
      if (st_q.serial_mode_field == MODE_SYNC) begin
        st_d.tx_st = ST_DATA;
        st_d.txd   = pop_s.data[0];
        st_d.tx_sh = {1'b0, pop_s.data[8:1]};
        st_d.sclk  = 1'b0;
      end else begin
        st_d.tx_st = ST_START;
        st_d.txd   = 1'b0;
      end
    end else begin
      if (tx_mid && st_q.serial_mode_field == MODE_SYNC && st_q.tx_st == ST_DATA) begin
        st_d.sclk = 1'b1;
      end
      if (tx_tick) begin
        unique case (st_q.tx_st)
          ST_START: begin
            st_d.tx_st = ST_DATA;
            st_d.txd   = st_q.tx_sh[0];
            st_d.tx_sh = {1'b0, st_q.tx_sh[8:1]};
          end
          ST_DATA: begin
            if (st_q.tx_cnt != LAST_BIT) begin
              st_d.tx_cnt = st_q.tx_cnt + 3'h1;
              st_d.txd    = st_q.tx_sh[0];
              st_d.tx_sh  = {1'b0, st_q.tx_sh[8:1]};
              st_d.sclk   = (st_q.serial_mode_field != MODE_SYNC);
            end else if (st_q.serial_mode_field == MODE_SYNC) begin
              st_d.tx_st         = ST_IDLE;
              st_d.transmit_flag = 1'b1;
            end else if (nine_bit) begin
              st_d.tx_st = ST_NINTH;
              st_d.txd   = st_q.tx_sh[0];
            end else begin
              st_d.tx_st         = ST_STOP;
              st_d.txd           = 1'b1;
              st_d.transmit_flag = 1'b1;
            end
          end
          ST_NINTH: begin
            st_d.tx_st         = ST_STOP;
            st_d.txd           = 1'b1;
            st_d.transmit_flag = 1'b1;
          end
          ST_STOP: st_d.tx_st = ST_IDLE;
          ST_IDLE: st_d.txd = 1'b1;
          default: st_d.tx_st = ST_IDLE;
        endcase
      end
    end

    // Receive frame
    unique case (st_q.rx_st)
      ST_IDLE: if (rx_go) st_d.rx_st = ST_START;
      ST_START: begin
        if (rx_mid && st_q.rxd_sync) begin
          st_d.rx_st = ST_IDLE;
        end else if (rx_tick) begin
          st_d.rx_st  = ST_DATA;
          st_d.rx_cnt = '0;
        end
      end
      ST_DATA, ST_NINTH: begin
        if (rx_mid) begin
          st_d.rx_sh = {st_q.rxd_sync, st_q.rx_sh[8:1]};
        end
        if (rx_tick) begin
          st_d.rx_cnt = st_q.rx_cnt + 3'h1;
          if (st_q.rx_st == ST_NINTH || (st_q.rx_cnt == LAST_BIT && !nine_bit)) begin
            st_d.rx_st = ST_STOP;
          end else if (st_q.rx_cnt == LAST_BIT) begin
            st_d.rx_st = ST_NINTH;
          end
        end
      end
      ST_STOP: begin
        if (rx_mid) begin
          st_d.rx_st = ST_IDLE;
          if (!st_q.rxd_sync) begin
            st_d.frame_error_flag = 1'b1;
          end
          if (accept) begin
            if (st_q.receive_flag && !(wr_serial_control_reg && !sfr_wdata[SERIAL_CONTROL_REG_RI])) begin
              st_d.receive_overrun_flag = 1'b1;
            end else begin
              st_d.rx_latch     = rx_byte;
              st_d.rx_bit9      = rx_b9;
              st_d.receive_flag = 1'b1;
            end
          end
        end
      end
      default: st_d.rx_st = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_q               <= '0;
      st_q.tx_st         <= ST_IDLE;
      st_q.rx_st         <= ST_IDLE;
      st_q.txd           <= 1'b1;
      st_q.sclk          <= 1'b1;
      st_q.rxd_meta      <= 1'b1;
      st_q.rxd_sync      <= 1'b1;
      st_q.threshold_pin <= THR_NORMAL;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata         = st_q.rdata;
  assign txd_pin           = st_q.txd;
  assign shift_clk         = st_q.sclk;
  assign rx_threshold_sel  = st_q.threshold_pin;
  assign powerdown_request = st_q.powerdown_req;
  assign idle_request      = st_q.idle_req;

  // ==========================================================================
  // Checks
  buf_write_starts_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_serial_data_buffer && push_s.ready && !pop_s.valid && st_q.tx_st == ST_IDLE) |-> ##2 st_q.tx_st != ST_IDLE)
    else $error("buffer write did not start a frame");
  buf_read_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sfr_rd && sfr_addr == ADDR_SERIAL_DATA_BUFFER) |=> sfr_rdata == $past(st_q.rx_latch))
    else $error("buffer read did not return receive latch");
  fixed_rate_double_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tx_tick && st_q.serial_mode_field == MODE_FIX9 && st_q.baud_doubler && st_q.tx_st == ST_DATA
     && st_q.tx_cnt < 3'h6) |-> ##32 tx_tick)
    else $error("doubled fixed bit time wrong");
  status_view_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sfr_rd && sfr_addr == ADDR_SERIAL_CONTROL_REG && st_q.status_view_select) |=>
    sfr_rdata[7:5] == {$past(st_q.frame_error_flag), $past(st_q.receive_overrun_flag),
                       $past(st_q.transmit_collision_flag)})
    else $error("status view not shown");
  slave_addr_store_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sfr_wr && sfr_addr == ADDR_NODE_SLAVE_ADDRESS) |=> st_q.node_slave_address == $past(sfr_wdata))
    else $error("slave address not stored");
  masked_match_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($rose(st_q.receive_flag) && !$past(wr_serial_control_reg) && st_q.multiproc_enable && nine_bit) |->
    st_q.rx_bit9 && ((st_q.rx_latch ^ st_q.node_slave_address) & st_q.node_address_mask) == 8'h00)
    else $error("unmatched address accepted");
  threshold_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !st_q.rx_enable |=> rx_threshold_sel == THR_NORMAL)
    else $error("threshold applied while port off");
  general_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sfr_wr && sfr_addr == ADDR_POWER_AND_SERIAL_CONTROL) |=> st_q.general_flags == $past(sfr_wdata[3:2])
    && powerdown_request == $past(sfr_wdata[1]) && idle_request == $past(sfr_wdata[0]))
    else $error("power control write not held");
  frame_error_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (st_q.frame_error_flag && !wr_serial_control_reg) |=> st_q.frame_error_flag)
    else $error("frame error cleared without software");
endmodule // spb_serial_ctrl

// ---- verification/spb_remote_node.sv ----
/*
  Remote serial node for mode 2 frames: captures what the port sends and
  sends frames to it. Assumes the bench sets bit_period in system clocks.
*/
module spb_remote_node (
  input  wire logic       sys_clk,
  input  wire logic       txd_pin,
  input  wire logic [6:0] bit_period,
  output logic            rxd_pin,
  output logic            got_valid,
  output logic      [8:0] got_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Idle line is high
  initial begin
    rxd_pin = 1'b1;
    got_valid = 1'b0;
    got_data = '0;
  end
  // Capture: mid-bit samples after the start edge, LSB first
  always begin
    @(negedge txd_pin);
    repeat (bit_period / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_period) @(posedge sys_clk);
      got_data[i] = txd_pin;
    end
    repeat (bit_period) @(posedge sys_clk);
    got_valid <= 1'b1;
    @(posedge sys_clk);
    got_valid <= 1'b0;
  end
  // Send start, nine bits LSB first, then the given stop level
  task automatic send(input logic [8:0] v, input logic stop);
    for (int i = -1; i < 11; i++) begin
      @(posedge sys_clk);
      rxd_pin <= (i < 0) ? 1'b0 : (i < 9) ? v[i] : (i == 9) ? stop : 1'b1;
      repeat (bit_period - 1) @(posedge sys_clk);
    end
  endtask
endmodule // spb_remote_node

// ---- verification/tb_top.sv ----
/*
  Self-checking bench of spb_serial_ctrl: registers, mode 2 frames both ways.
  Assumes spb_remote_node on the serial lines.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import spb_pkg::*;
  logic        sys_clk, rst_n, sfr_wr, sfr_rd, timer4_ovf, rxd_pin, txd_pin, shift_clk;
  logic        powerdown_request, idle_request, tx_buf_ready, got_valid, rd_seen;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, serial_control_reg_v;
  logic [1:0]  rx_threshold_sel;
  logic [6:0]  bit_period;
  logic [8:0]  got_data;
  logic [15:0] rd_q[$];
  logic [8:0]  fr_q[$];
  logic [31:0] seed;
  int          errors, checked;
  logic [7:0]  regs [7] = '{ADDR_POWER_AND_SERIAL_CONTROL, ADDR_SERIAL_CONTROL_REG, ADDR_SERIAL_DATA_BUFFER, ADDR_NODE_SLAVE_ADDRESS, ADDR_SMASK, ADDR_RXTHR, 8'h80};

  spb_serial_ctrl DUT (.sys_clk, .rst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .timer4_ovf,
    .rxd_pin, .txd_pin, .shift_clk, .rx_threshold_sel, .powerdown_request, .idle_request, .tx_buf_ready);
  spb_remote_node u_node (.sys_clk, .txd_pin, .bit_period, .rxd_pin, .got_valid, .got_data);

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic compare(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Write; an accepted buffer write notes the frame it should send
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    if (a == ADDR_SERIAL_CONTROL_REG) serial_control_reg_v = d;
    @(negedge sys_clk);
    if (a == ADDR_SERIAL_DATA_BUFFER && tx_buf_ready === 1'b1) fr_q.push_back({serial_control_reg_v[SERIAL_CONTROL_REG_TB8], d});
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    rd_q.push_back({m, e});
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
  endtask
  task automatic settle();
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic drain();
    for (int i = 0; i < 20000 && fr_q.size() > 0; i++) @(posedge sys_clk);
  endtask

  // ==========================================================================
  // Monitors: read data one cycle after the strobe, and captured frames
  always @(posedge sys_clk) rd_seen <= sfr_rd;
  always @(negedge sys_clk) if (rd_seen === 1'b1) begin
    compare({1'b0, sfr_rdata & rd_q[0][15:8]}, {1'b0, rd_q[0][7:0]});
    void'(rd_q.pop_front());
  end
  always @(posedge sys_clk) if (got_valid === 1'b1) compare(got_data, fr_q.pop_front());

  // Clock, watchdog
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial begin
    #200000;
    errors++;
    complete_run();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {rst_n, sfr_wr, sfr_rd, timer4_ovf, sfr_addr, sfr_wdata, serial_control_reg_v} = '0;
    {errors, checked} = '0;
    bit_period = DIV_FIX;
    seed = 32'hd6f3;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (regs[i]) rd(regs[i], RST_BYTE, 8'hff);
    compare({7'h0, rx_threshold_sel}, {7'h0, THR_NORMAL});
    $display("test reset done");
    seed = lfsr(seed);
    wr(ADDR_NODE_SLAVE_ADDRESS, seed[7:0]);
    rd(ADDR_NODE_SLAVE_ADDRESS, seed[7:0], 8'hff);
    wr(ADDR_SMASK, seed[15:8]);
    rd(ADDR_SMASK, seed[15:8], 8'hff);
    wr(ADDR_POWER_AND_SERIAL_CONTROL, 8'h3f);
    rd(ADDR_POWER_AND_SERIAL_CONTROL, 8'h0f, 8'hff);
    settle();
    compare({7'h0, powerdown_request, idle_request}, 9'h3);
    wr(ADDR_POWER_AND_SERIAL_CONTROL, 8'h00);
    wr(ADDR_RXTHR, 8'hfe);
    rd(ADDR_RXTHR, 8'h02, 8'hff);
    settle();
    compare({7'h0, rx_threshold_sel}, {7'h0, THR_NORMAL});
    wr(ADDR_SERIAL_CONTROL_REG, 8'h98);
    for (int t = 0; t < 4; t++) begin
      wr(ADDR_RXTHR, 8'(t));
      settle();
      compare({7'h0, rx_threshold_sel}, 9'(t));
    end
    $display("test registers done");
    repeat (6) begin
      seed = lfsr(seed);
      wr(ADDR_SERIAL_DATA_BUFFER, seed[7:0]);
    end
    wr(ADDR_POWER_AND_SERIAL_CONTROL, 8'h40);
    rd(ADDR_SERIAL_CONTROL_REG, 8'h20, 8'h20);
    drain();
    bit_period = DIV_FIX_DBL;
    wr(ADDR_POWER_AND_SERIAL_CONTROL, 8'h80);
    wr(ADDR_SERIAL_DATA_BUFFER, seed[15:8]);
    drain();
    $display("test transmit done");
    u_node.send({1'b1, seed[23:16]}, 1'b1);
    rd(ADDR_SERIAL_DATA_BUFFER, seed[23:16], 8'hff);
    rd(ADDR_SERIAL_CONTROL_REG, 8'h85, 8'hc5);
    wr(ADDR_SERIAL_CONTROL_REG, 8'h98);
    u_node.send(9'h0f0, 1'b0);
    wr(ADDR_POWER_AND_SERIAL_CONTROL, 8'hc0);
    rd(ADDR_SERIAL_CONTROL_REG, 8'h80, 8'h80);
    wr(ADDR_POWER_AND_SERIAL_CONTROL, 8'h80);
    wr(ADDR_NODE_SLAVE_ADDRESS, 8'h5a);
    wr(ADDR_SMASK, 8'hf0);
    wr(ADDR_SERIAL_CONTROL_REG, 8'hb8);
    u_node.send(9'h153, 1'b1);
    rd(ADDR_SERIAL_DATA_BUFFER, 8'h53, 8'hff);
    wr(ADDR_SERIAL_CONTROL_REG, 8'hb8);
    u_node.send(9'h1a3, 1'b1);
    u_node.send(9'h05c, 1'b1);
    rd(ADDR_SERIAL_CONTROL_REG, 8'h00, 8'h01);
    rd(ADDR_SERIAL_DATA_BUFFER, 8'h53, 8'hff);
    timer4_ovf <= 1'b1;
    bit_period = DIV_VAR_DBL;
    wr(ADDR_SERIAL_CONTROL_REG, 8'hd8);
    wr(ADDR_SERIAL_DATA_BUFFER, seed[31:24]);
    drain();
    settle();
    $display("test receive done");
    complete_run();
  end
endmodule // tb_top
